/* File: du_cfg.svh */
// offsets, field positions, reset values and rate divisors of the dual uart
`ifndef DU_CFG_SVH
`define DU_CFG_SVH

// register index; byte address is four times the index
`define DU_IDX_POWER_RATE 16'h0087
`define DU_IDX_RATE_SRC 16'h00d8
`define DU_IDX_PIN_ROUTE 16'hfff1
`define DU_IDX_CH0_CTRL 16'h009b
`define DU_IDX_CH0_DATA 16'h0099
`define DU_IDX_CH0_RELL 16'h00aa
`define DU_IDX_CH0_RELH 16'h00ba
`define DU_IDX_CH1_CTRL 16'h009c
`define DU_IDX_CH1_DATA 16'h009d
`define DU_IDX_CH1_RELL 16'h009e
`define DU_IDX_CH1_RELH 16'h009f

// field positions
`define DU_DBL_BIT 7
`define DU_SRC_BIT 7
`define DU_ROUTE_BIT 0
`define DU_LOOP_BIT 1
`define DU_MODE_HI 7
`define DU_MODE_LO 6
`define DU_CH1_8BIT_BIT 7
`define DU_REN_BIT 4
`define DU_TB8_BIT 3
`define DU_RB8_BIT 2
`define DU_TI_BIT 1
`define DU_RI_BIT 0

// reset value and implemented-bit masks
`define DU_RST_REG 8'h00
`define DU_SRC_MASK 8'h80
`define DU_ROUTE_MASK 8'h83
`define DU_RELH_MASK 8'h03

// oversample ticks per bit, then divisors in core clock cycles per bit
`define DU_OVS 16
`define DU_T1_DIV 384
`define DU_GEN0_DIV 64
`define DU_GEN1_DIV 32
`define DU_M2_DIV 64
`define DU_SHIFT_DIV 12

`endif

/* File: du_host.sv */
// serial host model standing on the far side of the shared pins
`timescale 1ns/1ps
module du_host (
   input logic mclk,
   input logic tx_pin,
   output logic rx_line
);
   // line idles high like a pulled-up uart wire
   initial rx_line = 1'b1;
   task automatic send(input int bc, input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx_line <= f[i];
         repeat (bc) @(posedge mclk);
      end
   endtask : send
   task automatic recv(input int bc, input int nb, output logic [9:0] f);
      int n;
      n = 0;
      f = 10'h0;
      while (tx_pin !== 1'b0 && n < 20000) begin
         @(posedge mclk);
         n++;
      end
      repeat (bc / 2) @(posedge mclk);
      for (int i = 0; i < nb; i++) begin
         repeat (bc) @(posedge mclk);
         f[i] = tx_pin;
      end
      // return past the stop bit so done flags have landed
      repeat (bc) @(posedge mclk);
   endtask : recv
endmodule : du_host

/* File: du_pkg.sv */
// types shared by the dual uart design
package du_pkg;
   typedef logic [7:0] du_byte_t;
   typedef logic [15:0] du_idx_t;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_SEND = 3'b010,
      TX_SHIFT = 3'b100
   } du_tx_state_t;
   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_START = 3'b010,
      RX_DATA = 3'b100
   } du_rx_state_t;
endpackage : du_pkg

/* File: du_uart.sv */
// dual serial channel with shared pins, rate generators and avalon slave
// Functional notes
// - only one channel owns the pins; route bit 1 picks channel 1
// - loopback cross-connects routed channel transmit to other channel receive
// - bytes go out and come in least significant bit first
// - programmable rates over the supported span; parity handled by software
// - timer 1 source: rate is 2^dbl * fclk / (384 * (256 - t1 high))
// - generator source: rate is 2^dbl * fclk / (64 * (1024 - reload))
// - reload value is high register bits 1:0 above low register byte
// - doubling bit set doubles channel 0 rate
// - source bit 0 picks timer 1, 1 picks internal generator
// - shift mode: rx pin carries data, tx pin the clock, fclk/12
// - shift mode reception starts when receive flag 0 and enable 1
// - async modes start receiving on a start bit while enabled
// - 8-bit frame: start 0, eight data, stop 1, ten bits
// - 8-bit receive stores byte and copies stop bit into ninth flag
// - channel 0 8-bit mode timed by generator or timer 1
// - channel 0 mode 2: 9-bit frame at fclk/32 or fclk/64
// - mode 3 9-bit variable rate; channel 1 has 9-bit and 8-bit
// - ninth bit written and read by software; no hardware parity
// - mode field: 00 shift, 01 8-bit, 10 fixed 9-bit, 11 variable 9-bit
// - 9-bit frame is eleven bits; ninth bit sent and captured
// - transmit done flag set by hardware, cleared only by software
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps

`include "du_cfg.svh"

module du_chan (
   input logic mclk,
   input logic reset,
   input logic tick,
   input logic sh_tick,
   input logic shift_mode,
   input logic nine_bit,
   input logic ren,
   input logic ri,
   input logic tb8,
   input logic tx_start,
   input du_pkg::du_byte_t tx_byte,
   input logic rx_in,
   input logic sh_in,
   output logic tx_out,
   output logic sclk_out,
   output logic sh_out,
   output logic sh_drive,
   output logic busy,
   output logic tx_done,
   output logic rx_done,
   output logic rx_ninth,
   output du_pkg::du_byte_t rx_byte
);
   import du_pkg::*;

   du_tx_state_t tx_st_q;
   du_rx_state_t rx_st_q;
   logic [9:0] tsr_q;
   logic [3:0] tbit_q;
   logic [3:0] tovs_q;
   logic [3:0] rbit_q;
   logic [3:0] rovs_q;
   logic sh_phase_q;
   logic sh_dir_q;
   logic sh_fin_q;
   logic [7:0] rsr_q;
   logic r9_q;
   logic [3:0] tlast;
   logic [3:0] rlast;

   // eleven-bit frame in 9-bit modes, ten otherwise
   assign tlast = nine_bit ? 4'ha : 4'h9;
   assign rlast = nine_bit ? 4'h9 : 4'h8;
   assign busy = (tx_st_q != TX_IDLE);

   // ------------------------------------------------------------
   // transmitter and shift-mode sequencer
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tx_st_q <= TX_IDLE;
         tsr_q <= 10'h3ff;
         tbit_q <= 4'h0;
         tovs_q <= 4'h0;
         tx_out <= 1'b1;
         sclk_out <= 1'b1;
         sh_out <= 1'b1;
         sh_drive <= 1'b0;
         sh_phase_q <= 1'b0;
         sh_dir_q <= 1'b0;
         sh_fin_q <= 1'b0;
         tx_done <= 1'b0;
      end else begin
         tx_done <= 1'b0;
         sh_fin_q <= 1'b0;
         case (tx_st_q)
            TX_IDLE: begin
               tbit_q <= 4'h0;
               tovs_q <= 4'h0;
               sh_phase_q <= 1'b0;
               // write starts a frame only from idle
               if (tx_start && shift_mode) begin
                  tsr_q <= {2'h3, tx_byte};
                  sh_dir_q <= 1'b1;
                  sh_drive <= 1'b1;
                  tx_st_q <= TX_SHIFT;
               end else if (tx_start) begin
                  // start bit driven low at once
                  tsr_q <= {1'b1, nine_bit ? tb8 : 1'b1, tx_byte};
                  tx_out <= 1'b0;
                  tx_st_q <= TX_SEND;
               end else if (shift_mode && ren && !ri) begin
                  // shift reception armed by flag and enable
                  sh_dir_q <= 1'b0;
                  tx_st_q <= TX_SHIFT;
               end
            end
            TX_SEND: begin
               if (tick) begin
                  tovs_q <= tovs_q + 4'h1;
                  if (tovs_q == 4'hf) begin
                     if (tbit_q == tlast) begin
                        tx_out <= 1'b1;
                        tx_done <= 1'b1;
                        tx_st_q <= TX_IDLE;
                     end else begin
                        tx_out <= tsr_q[0];
                        tsr_q <= {1'b1, tsr_q[9:1]};
                        tbit_q <= tbit_q + 4'h1;
                     end
                  end
               end
            end
            TX_SHIFT: begin
               // clock on tx pin, data on rx pin
               if (sh_tick) begin
                  sh_phase_q <= !sh_phase_q;
                  if (!sh_phase_q) begin
                     sclk_out <= 1'b0;
                     sh_out <= sh_dir_q ? tsr_q[0] : 1'b1;
                  end else begin
                     sclk_out <= 1'b1;
                     tsr_q[7:0] <= {sh_in, tsr_q[7:1]};
                     tbit_q <= tbit_q + 4'h1;
                     if (tbit_q == 4'h7) begin
                        sh_drive <= 1'b0;
                        sh_out <= 1'b1;
                        tx_done <= sh_dir_q;
                        sh_fin_q <= !sh_dir_q;
                        tx_st_q <= TX_IDLE;
                     end
                  end
               end
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // receiver, 16x oversampled
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rx_st_q <= RX_IDLE;
         rsr_q <= 8'h00;
         r9_q <= 1'b0;
         rbit_q <= 4'h0;
         rovs_q <= 4'h0;
         rx_done <= 1'b0;
         rx_ninth <= 1'b0;
         rx_byte <= 8'h00;
      end else begin
         rx_done <= 1'b0;
         if (sh_fin_q) begin
            rx_byte <= tsr_q[7:0];
            rx_done <= 1'b1;
         end
         case (rx_st_q)
            RX_IDLE: begin
               rovs_q <= 4'h0;
               rbit_q <= 4'h0;
               // low line seen on a tick while enabled opens a frame
               if (tick && ren && !shift_mode && !rx_in) begin
                  rx_st_q <= RX_START;
               end
            end
            RX_START: begin
               if (tick) begin
                  rovs_q <= rovs_q + 4'h1;
                  // glitch filter: start must still be low mid-bit
                  if (rovs_q == 4'h7) begin
                     rovs_q <= 4'h0;
                     rx_st_q <= rx_in ? RX_IDLE : RX_DATA;
                  end
               end
            end
            RX_DATA: begin
               if (tick) begin
                  rovs_q <= rovs_q + 4'h1;
                  if (rovs_q == 4'hf) begin
                     rbit_q <= rbit_q + 4'h1;
                     // first bit ends up in bit 0
                     if (rbit_q < 4'h8) begin
                        rsr_q <= {rx_in, rsr_q[7:1]};
                     end else if (rbit_q == 4'h8) begin
                        r9_q <= rx_in;
                     end
                     if (rbit_q == rlast) begin
                        // byte stored, stop or ninth bit kept
                        rx_byte <= rsr_q;
                        rx_ninth <= nine_bit ? r9_q : rx_in;
                        rx_done <= 1'b1;
                        rx_st_q <= RX_IDLE;
                     end
                  end
               end
            end
            default: rx_st_q <= RX_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   sequence s_start_low;
      !tx_out [*2];
   endsequence
   property p_start_bit;
      (tx_start && !busy && !shift_mode) |=> s_start_low;
   endproperty
   a_start_bit: assert property (p_start_bit)
      else $error("start bit not driven low");
endmodule : du_chan

module du_uart (
   input logic mclk,
   input logic reset,
   input logic [17:0] avs_address,
   input logic avs_read,
   input logic avs_write,
   input logic [3:0] avs_byteenable,
   input logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input du_pkg::du_byte_t timer1_high_byte,
   input logic rx_pin_i,
   output logic rx_pin_o,
   output logic rx_pin_oe_n,
   output logic tx_pin
);
   import du_pkg::*;

   localparam du_idx_t CTRL_IDX [2] = '{`DU_IDX_CH0_CTRL, `DU_IDX_CH1_CTRL};
   localparam du_idx_t DATA_IDX [2] = '{`DU_IDX_CH0_DATA, `DU_IDX_CH1_DATA};
   localparam du_idx_t RELL_IDX [2] = '{`DU_IDX_CH0_RELL, `DU_IDX_CH1_RELL};
   localparam du_idx_t RELH_IDX [2] = '{`DU_IDX_CH0_RELH, `DU_IDX_CH1_RELH};

   // cycles per oversample tick for one channel
   function automatic logic [15:0] rate_period(input logic fixed,
         input logic use_gen, input logic dbl, input logic [9:0] rel,
         input logic [7:0] th1, input logic [15:0] gscale);
      logic [15:0] base;
      if (fixed) begin
         base = 16'(`DU_M2_DIV / `DU_OVS);
      end else if (use_gen) begin
         base = gscale * (16'h0400 - {6'h00, rel});
      end else begin
         base = 16'(`DU_T1_DIV / `DU_OVS) * (16'h0100 - {8'h00, th1});
      end
      return dbl ? (base >> 1) : base;
   endfunction : rate_period

   logic ack_q;
   logic [31:0] rdata_q;
   du_byte_t rd_byte;
   du_byte_t wb;
   du_idx_t idx;
   logic wr_en;
   du_byte_t power_q;
   du_byte_t src_q;
   du_byte_t route_q;
   du_byte_t ctrl_q [2];
   du_byte_t rell_q [2];
   du_byte_t relh_q [2];
   logic [9:0] rel [2];
   logic [15:0] per [2];
   logic [15:0] rcnt_q [2];
   logic [1:0] tick_q;
   logic [2:0] sh_cnt_q;
   logic sh_tick_q;
   logic [1:0] tx_start;
   logic [1:0] shift_m;
   logic [1:0] nine_m;
   logic [1:0] rx_feed;
   logic [1:0] c_tx;
   logic [1:0] c_sclk;
   logic [1:0] c_sh_out;
   logic [1:0] c_sh_drive;
   logic [1:0] c_busy;
   logic [1:0] c_tx_done;
   logic [1:0] c_rx_done;
   logic [1:0] c_rx9;
   du_byte_t c_rx_byte [2];

   // ------------------------------------------------------------
   // avalon slave: one wait state on every access
   // ------------------------------------------------------------
   assign idx = avs_address[17:2];
   assign wb = avs_writedata[7:0];
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign avs_readdata = rdata_q;
   assign wr_en = avs_write && ack_q && avs_byteenable[0];

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdata_q <= 32'h00000000;
      end else if (avs_read && !ack_q) begin
         rdata_q <= {24'h000000, rd_byte};
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      case (idx)
         `DU_IDX_POWER_RATE: rd_byte = power_q;
         `DU_IDX_RATE_SRC: rd_byte = src_q;
         `DU_IDX_PIN_ROUTE: rd_byte = route_q;
         default: begin
            for (int i = 0; i < 2; i++) begin
               if (idx == CTRL_IDX[i]) rd_byte = ctrl_q[i];
               if (idx == DATA_IDX[i]) rd_byte = c_rx_byte[i];
               if (idx == RELL_IDX[i]) rd_byte = rell_q[i];
               if (idx == RELH_IDX[i]) rd_byte = relh_q[i];
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // global control registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         power_q <= `DU_RST_REG;
         src_q <= `DU_RST_REG;
         route_q <= `DU_RST_REG;
      end else if (wr_en) begin
         if (idx == `DU_IDX_POWER_RATE) power_q <= wb;
         if (idx == `DU_IDX_RATE_SRC) src_q <= wb & `DU_SRC_MASK;
         if (idx == `DU_IDX_PIN_ROUTE) route_q <= wb & `DU_ROUTE_MASK;
      end
   end

   // ------------------------------------------------------------
   // per-channel control, flags and reload
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 2; i++) begin
            ctrl_q[i] <= `DU_RST_REG;
            rell_q[i] <= `DU_RST_REG;
            relh_q[i] <= `DU_RST_REG;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_en && idx == CTRL_IDX[i]) ctrl_q[i] <= wb;
            if (wr_en && idx == RELL_IDX[i]) rell_q[i] <= wb;
            if (wr_en && idx == RELH_IDX[i]) begin
               relh_q[i] <= wb & `DU_RELH_MASK;
            end
            // hardware only sets the done flags and loads the ninth bit; later assignment beats a clear
            if (c_tx_done[i]) ctrl_q[i][`DU_TI_BIT] <= 1'b1;
            if (c_rx_done[i]) begin
               ctrl_q[i][`DU_RI_BIT] <= 1'b1;
               if (!shift_m[i]) ctrl_q[i][`DU_RB8_BIT] <= c_rx9[i];
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         rel[i] = {relh_q[i][1:0], rell_q[i]};
         tx_start[i] = wr_en && (idx == DATA_IDX[i]);
      end
      shift_m[0] = (ctrl_q[0][`DU_MODE_HI:`DU_MODE_LO] == 2'h0);
      nine_m[0] = ctrl_q[0][`DU_MODE_HI];
      // channel 1: 9-bit or 8-bit framing
      shift_m[1] = 1'b0;
      nine_m[1] = !ctrl_q[1][`DU_CH1_8BIT_BIT];
      // fixed rate in mode 2; source select; doubling
      per[0] = rate_period(ctrl_q[0][`DU_MODE_HI:`DU_MODE_LO] == 2'h2,
         src_q[`DU_SRC_BIT], power_q[`DU_DBL_BIT], rel[0],
         timer1_high_byte, 16'(`DU_GEN0_DIV / `DU_OVS));
      // channel 1 always on its own generator
      per[1] = rate_period(1'b0, 1'b1, 1'b0, rel[1], timer1_high_byte,
         16'(`DU_GEN1_DIV / `DU_OVS));
   end

   // ------------------------------------------------------------
   // rate generators
   // ------------------------------------------------------------
   // programmable oversample tick per channel
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tick_q <= 2'h0;
         for (int i = 0; i < 2; i++) rcnt_q[i] <= 16'h0000;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (rcnt_q[i] >= per[i] - 16'h0001) begin
               rcnt_q[i] <= 16'h0000;
               tick_q[i] <= 1'b1;
            end else begin
               rcnt_q[i] <= rcnt_q[i] + 16'h0001;
               tick_q[i] <= 1'b0;
            end
         end
      end
   end

   // shift clock: enable at twice the twelfth-of-clock rate
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sh_cnt_q <= 3'h0;
         sh_tick_q <= 1'b0;
      end else if (sh_cnt_q == 3'(`DU_SHIFT_DIV / 2 - 1)) begin
         sh_cnt_q <= 3'h0;
         sh_tick_q <= 1'b1;
      end else begin
         sh_cnt_q <= sh_cnt_q + 3'h1;
         sh_tick_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // channels and pin routing
   // ------------------------------------------------------------
   // loopback feeds the idle channel from the routed transmitter
   always_comb begin
      if (route_q[`DU_ROUTE_BIT]) begin
         rx_feed[0] = route_q[`DU_LOOP_BIT] ? c_tx[1] : 1'b1;
         rx_feed[1] = rx_pin_i;
      end else begin
         rx_feed[0] = rx_pin_i;
         rx_feed[1] = route_q[`DU_LOOP_BIT] ? c_tx[0] : 1'b1;
      end
   end

   for (genvar i = 0; i < 2; i++) begin : g_ch
      du_chan u_chan (
         .mclk(mclk),
         .reset(reset),
         .tick(tick_q[i]),
         .sh_tick(sh_tick_q),
         .shift_mode(shift_m[i]),
         .nine_bit(nine_m[i]),
         .ren(ctrl_q[i][`DU_REN_BIT]),
         .ri(ctrl_q[i][`DU_RI_BIT]),
         .tb8(ctrl_q[i][`DU_TB8_BIT]),
         .tx_start(tx_start[i]),
         .tx_byte(wb),
         .rx_in(rx_feed[i]),
         .sh_in(rx_pin_i),
         .tx_out(c_tx[i]),
         .sclk_out(c_sclk[i]),
         .sh_out(c_sh_out[i]),
         .sh_drive(c_sh_drive[i]),
         .busy(c_busy[i]),
         .tx_done(c_tx_done[i]),
         .rx_done(c_rx_done[i]),
         .rx_ninth(c_rx9[i]),
         .rx_byte(c_rx_byte[i])
      );
   end

   // single owner of the shared pins
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tx_pin <= 1'b1;
         rx_pin_o <= 1'b1;
         rx_pin_oe_n <= 1'b1;
      end else begin
         if (route_q[`DU_ROUTE_BIT]) begin
            tx_pin <= c_tx[1];
         end else begin
            tx_pin <= shift_m[0] ? c_sclk[0] : c_tx[0];
         end
         rx_pin_o <= c_sh_out[0];
         rx_pin_oe_n <= !(c_sh_drive[0] && !route_q[`DU_ROUTE_BIT]);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [15:0] gap_q;
   logic stable_q;
   logic [15:0] per0_prev_q;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         gap_q <= 16'h0000;
         stable_q <= 1'b0;
         per0_prev_q <= 16'h0000;
      end else begin
         per0_prev_q <= per[0];
         gap_q <= tick_q[0] ? 16'h0000 : gap_q + 16'h0001;
         if (tick_q[0]) stable_q <= 1'b1;
         else if (per[0] != per0_prev_q) stable_q <= 1'b0;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   property p_route_sel1;
      route_q[`DU_ROUTE_BIT] |=> tx_pin == $past(c_tx[1]);
   endproperty
   a_route_sel1: assert property (p_route_sel1)
      else $error("tx pin not owned by channel 1");

   property p_loop0;
      (route_q[`DU_LOOP_BIT] && !route_q[`DU_ROUTE_BIT])
         |-> rx_feed[1] == c_tx[0];
   endproperty
   a_loop0: assert property (p_loop0)
      else $error("loopback path broken");

   property p_ti_set;
      c_tx_done[0] |=> ctrl_q[0][`DU_TI_BIT];
   endproperty
   a_ti_set: assert property (p_ti_set)
      else $error("transmit done flag not set");

   property p_ti_hold;
      (ctrl_q[1][`DU_TI_BIT] && !(wr_en && idx == CTRL_IDX[1]))
         |=> ctrl_q[1][`DU_TI_BIT];
   endproperty
   a_ti_hold: assert property (p_ti_hold)
      else $error("transmit done flag cleared by hardware");

   property p_rate_gap;
      (tick_q[0] && stable_q && per[0] == per0_prev_q)
         |-> gap_q == per[0] - 16'h0001;
   endproperty
   a_rate_gap: assert property (p_rate_gap)
      else $error("channel 0 tick spacing wrong");

   property p_tx_start1;
      (tx_start[1] && !c_busy[1]) |=> c_busy[1];
   endproperty
   a_tx_start1: assert property (p_tx_start1)
      else $error("data write did not start transmit");

   property p_shift_rx;
      (shift_m[0] && ctrl_q[0][`DU_REN_BIT] && !ctrl_q[0][`DU_RI_BIT]
         && !c_busy[0]) |=> c_busy[0];
   endproperty
   a_shift_rx: assert property (p_shift_rx)
      else $error("shift reception did not start");

   property p_bus_ack;
      (avs_read && avs_waitrequest) |=> !avs_waitrequest;
   endproperty
   a_bus_ack: assert property (p_bus_ack)
      else $error("read not answered after one wait state");
endmodule : du_uart

/* File: test_du_uart.sv */
// self-checking bench for the dual uart
`timescale 1ns/1ps
`include "du_cfg.svh"
module test_du_uart;
   import du_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [17:0] avs_address = 18'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   du_byte_t th1 = 8'hff;
   logic host_rx, rx_pin_o, rx_pin_oe_n, tx_pin;
   logic [9:0] f;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int c0 = 0;
   wire rx_wire = rx_pin_oe_n ? host_rx : rx_pin_o;
   always #4 mclk = ~mclk;
   du_uart i_du_uart (.mclk(mclk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h1),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .timer1_high_byte(th1),
      .rx_pin_i(rx_wire), .rx_pin_o(rx_pin_o), .rx_pin_oe_n(rx_pin_oe_n),
      .tx_pin(tx_pin));
   du_host i_du_host (.mclk(mclk), .tx_pin(tx_pin), .rx_line(host_rx));
   // ---------------------------------------
   // bus tasks and checks
   // ---------------------------------------
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input du_byte_t got, input du_byte_t exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input du_idx_t idx, input du_byte_t d,
         output du_byte_t q);
      @(posedge mclk);
      avs_address <= {idx, 2'b00};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, d};
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge mclk);
      end
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wr(input du_idx_t idx, input du_byte_t d);
      du_byte_t q;
      bus(1'b1, idx, d, q);
   endtask : wr
   task automatic rd(input du_idx_t idx, input du_byte_t exp);
      du_byte_t q;
      bus(1'b0, idx, 8'h00, q);
      chk(q, exp);
   endtask : rd
   // hang guard, generous against the slow timer 1 frame
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      rd(`DU_IDX_POWER_RATE, 8'h00);
      rd(`DU_IDX_RATE_SRC, 8'h00);
      rd(`DU_IDX_PIN_ROUTE, 8'h00);
      wr(`DU_IDX_PIN_ROUTE, 8'hfc);
      rd(`DU_IDX_PIN_ROUTE, 8'h80);
      wr(`DU_IDX_RATE_SRC, 8'hff);
      rd(`DU_IDX_RATE_SRC, 8'h80);
      wr(16'h0001, 8'h55);
      rd(16'h0001, 8'h00);
      $display("registers test done");
      wr(`DU_IDX_POWER_RATE, 8'h80);
      wr(`DU_IDX_CH0_RELL, 8'hff);
      wr(`DU_IDX_CH0_RELH, 8'hff);
      rd(`DU_IDX_CH0_RELH, 8'h03);
      wr(`DU_IDX_CH0_CTRL, 8'h50);
      wr(`DU_IDX_CH0_DATA, 8'ha5);
      i_du_host.recv(32, 9, f);
      chk(f[7:0], 8'ha5);
      chk({7'h0, f[8]}, 8'h01);
      rd(`DU_IDX_CH0_CTRL, 8'h52);
      wr(`DU_IDX_CH0_CTRL, 8'h50);
      rd(`DU_IDX_CH0_CTRL, 8'h50);
      i_du_host.send(32, 8'h3c);
      rd(`DU_IDX_CH0_DATA, 8'h3c);
      rd(`DU_IDX_CH0_CTRL, 8'h55);
      $display("channel 0 generator test done");
      wr(`DU_IDX_POWER_RATE, 8'h00);
      wr(`DU_IDX_RATE_SRC, 8'h00);
      wr(`DU_IDX_CH0_DATA, 8'h81);
      i_du_host.recv(384, 9, f);
      chk(f[7:0], 8'h81);
      $display("timer 1 test done");
      wr(`DU_IDX_POWER_RATE, 8'h80);
      wr(`DU_IDX_RATE_SRC, 8'h80);
      wr(`DU_IDX_CH1_RELL, 8'hff);
      wr(`DU_IDX_CH1_RELH, 8'h03);
      wr(`DU_IDX_CH1_CTRL, 8'h90);
      wr(`DU_IDX_PIN_ROUTE, 8'h01);
      wr(`DU_IDX_CH1_DATA, 8'h69);
      i_du_host.recv(32, 9, f);
      chk(f[7:0], 8'h69);
      $display("channel 1 test done");
      wr(`DU_IDX_PIN_ROUTE, 8'h02);
      wr(`DU_IDX_CH0_CTRL, 8'h50);
      wr(`DU_IDX_CH0_DATA, 8'h5a);
      i_du_host.recv(32, 9, f);
      chk(f[7:0], 8'h5a);
      rd(`DU_IDX_CH1_DATA, 8'h5a);
      $display("loopback test done");
      wr(`DU_IDX_PIN_ROUTE, 8'h00);
      // generator now twice as slow as the fixed mode 2 rate
      wr(`DU_IDX_CH0_RELL, 8'hfe);
      wr(`DU_IDX_CH0_CTRL, 8'h90);
      wr(`DU_IDX_CH0_DATA, 8'hc3);
      i_du_host.recv(32, 10, f);
      chk(f[7:0], 8'hc3);
      chk({6'h0, f[9:8]}, 8'h02);
      wr(`DU_IDX_CH0_CTRL, 8'hd8);
      wr(`DU_IDX_CH0_DATA, 8'h3e);
      i_du_host.recv(64, 10, f);
      chk(f[7:0], 8'h3e);
      chk({6'h0, f[9:8]}, 8'h03);
      $display("nine bit test done");
      wr(`DU_IDX_CH0_CTRL, 8'h00);
      wr(`DU_IDX_CH0_DATA, 8'hb4);
      for (int i = 0; i < 8; i++) begin
         @(posedge tx_pin);
         if (i == 0) c0 = cyc;
         f[i] = rx_wire;
      end
      chk(f[7:0], 8'hb4);
      chk(8'(cyc - c0), 8'h54);
      wr(`DU_IDX_CH0_CTRL, 8'h10);
      repeat (120) @(posedge mclk);
      rd(`DU_IDX_CH0_CTRL, 8'h11);
      rd(`DU_IDX_CH0_DATA, 8'hff);
      $display("shift mode test done");
      print_verdict();
   end
endmodule : test_du_uart
